// ---- mbsc_pkg.sv ----
/*
 Shared constants and types of the motor bridge control block.
 Assumes a 100 MHz system clock and a 16-bit serial frame word.
*/
package mbsc_pkg;
   // System clock rate
   localparam int CLK_MHZ = 100;
   // Serial word length and counter widths
   localparam int WORD_BITS = 16;
   localparam logic [3:0] LAST_BIT = 4'hF;
   localparam logic [4:0] RISE_WRAP = 5'h10;
   // Command word layout: write flag, address, data
   localparam int CMD_WR_POS = 15;
   localparam int CMD_ADDR_HI = 14;
   localparam int CMD_ADDR_LO = 13;
   localparam int CMD_DATA_HI = 7;
   // Register addresses
   localparam logic [1:0] ADDR_FAULT = 2'h0;
   localparam logic [1:0] ADDR_MASK = 2'h1;
   localparam logic [1:0] ADDR_SLEW = 2'h2;
   // Reset values
   localparam logic [7:0] MASK_RST = 8'hFF;
   localparam logic [2:0] SLEW_RST = 3'h3;
   // Dead time between switches of one half-bridge
   localparam int DEAD_NS = 500;
   localparam int DEAD_CYC_I = (DEAD_NS * CLK_MHZ + 999) / 1000;
   localparam logic [5:0] DEAD_CYC = 6'(DEAD_CYC_I);
   // Operating modes
   typedef enum logic [1:0] {MODE_SLEEP, MODE_STANDBY, MODE_ACTIVE} mbsc_mode_t;
   // Gate drive of one half-bridge
   typedef struct packed {
      logic drv_en;
      logic hs_on;
      logic ls_on;
   } mbsc_hb_t;
endpackage : mbsc_pkg

// ---- mbsc_spi_master.sv ----
/*
 Serial master model that drives the bridge's 16-bit serial slave.
 Assumes the bench calls xfer from one process at a time.
*/
`timescale 1ns/1ps
module mbsc_spi_master (
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   // Link clock idles low, select idles high
   // Select rises just after start so the link counters begin cleared
   initial begin
      sclk = 1'b0;
      mosi = 1'b0;
      #1 cs_n = 1'b1;
   end
   // One framed transfer of n bits, first bit sent first, 160 ns per bit
   task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
      rx = '0;
      cs_n = 1'b0;
      #80;
      for (int k = n - 1; k >= 0; k--) begin
         rx[k] = miso;
         mosi = tx[k];
         #40 sclk = 1'b1;
         #80 sclk = 1'b0;
         #40;
      end
      // Select rise applies the word; the released line shows no stale bit
      cs_n = 1'b1;
      mosi = ~mosi;
      #100;
   endtask : xfer
endmodule : mbsc_spi_master

// ---- mbsc_top.sv ----
/*
 Control logic of an H-bridge driver: mode pins, direction steering with
 dead time, fault flag and a 16-bit serial slave on its own clock.
 Assumes the master leaves at least 50 ns from chip select fall to the
 first serial clock edge, and that every pin input is asynchronous.
*/
// Functional notes
// - Wake low: all drivers off, sleep mode
// - Wake high: normal bridge operation
// - Inhibit high: drivers off, standby, not sleep
// - Inhibit low does not block outputs
// - Never both switches on in one half-bridge
// - Direction high drives high side, direction low drives low side
// - Direction change leaves dead gap, no overlap
// - Slew setting comes from slew register
// - Daisy-chainable serial slave, shared select
// - Sample on falling, update output on rising
// - Output words most significant bit first
// - After 16 bits, echo received bits
// - Output high impedance while select high
// - Accept input data only while selected
// - Select rise applies word to register
// - Select fall loads previously addressed register
// - Fault flag low on any unmasked fault
// - Direction A drives output A, B drives B
`timescale 1ns/1ps
module mbsc_top
   import mbsc_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic MOSI,
   output logic MISO_O,
   output logic MISO_OE,
   input wire logic BRIDGE_WAKE_IN,
   input wire logic OUTPUT_INHIBIT_IN,
   input wire logic DIRECTION_IN_A,
   input wire logic DIRECTION_IN_B,
   input wire logic [7:0] FAULT_IN,
   output mbsc_pkg::mbsc_hb_t BRIDGE_OUT_A,
   output mbsc_pkg::mbsc_hb_t BRIDGE_OUT_B,
   output logic FAULT_FLAG_N_O,
   output logic FAULT_FLAG_N_OE,
   output logic [2:0] SLEW_SEL,
   output mbsc_pkg::mbsc_mode_t BRIDGE_MODE
);
   import mbsc_pkg::*;

   // Serial clock domain state
   logic [WORD_BITS-1:0] rx_q; // Shift register, no reset
   logic [3:0] fall_cnt_q; // Bit position in word
   logic word_ok_q; // Last bit closed a word
   logic [4:0] rise_cnt_q; // Rising edges, saturating
   logic miso_q; // Output bit after first rise

   // System domain state
   logic [12:0] meta_q; // First synchroniser stage
   logic [12:0] sync_q; // Second synchroniser stage
   logic cs_d1_q; // Delayed select for edge detect
   logic [7:0] mask_q; // Fault status mask
   logic [2:0] slew_q; // Slew time selection
   logic [1:0] addr_prev_q; // Address of preceding transfer
   logic [WORD_BITS-1:0] tx_q; // Word shifted out next frame
   logic flag_q; // Fault flag drive
   mbsc_mode_t mode_q; // Operating mode
   logic [1:0] hs_q; // High-side switch per output
   logic [1:0] ls_q; // Low-side switch per output
   logic [1:0] drv_q; // Driver enable per output
   logic [5:0] dead_q [2]; // Dead-time counters

   // Named views of synchronised pins, select edge, command address and register read
   logic cs_s;
   logic wake_s;
   logic inh_s;
   logic [1:0] dir_s;
   logic [7:0] fault_s;
   logic cs_rise;
   logic [1:0] cmd_addr;
   logic [7:0] reg_rd;

   assign cs_s = sync_q[0];
   assign wake_s = sync_q[1];
   assign inh_s = sync_q[2];
   assign dir_s = sync_q[4:3];
   assign fault_s = sync_q[12:5];
   assign cs_rise = cs_s & ~cs_d1_q;
   assign cmd_addr = rx_q[CMD_ADDR_HI:CMD_ADDR_LO];

   // Receive shift on falling edge; count resets while deselected
   always_ff @(negedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         fall_cnt_q <= 4'h0; // Frame boundary
      end else begin
         fall_cnt_q <= fall_cnt_q + 4'h1; // Word boundary every 16
      end
   end

   // Data and word-complete flag survive select rise for the apply
   always_ff @(negedge SCLK) begin
      if (!CS_N) begin
         rx_q <= {rx_q[WORD_BITS-2:0], MOSI}; // Sample on fall
         word_ok_q <= (fall_cnt_q == LAST_BIT); // Last 16 bits are ours
      end
   end

   // Rising-edge count selects data or echo
   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         rise_cnt_q <= 5'h0;
      end else if (rise_cnt_q != RISE_WRAP) begin
         rise_cnt_q <= rise_cnt_q + 5'h1;
      end
   end

   // Output bit update on rising edge
   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         miso_q <= 1'b0;
      end else if (rise_cnt_q < 5'(WORD_BITS - 1)) begin
         miso_q <= tx_q[4'(WORD_BITS - 2) - rise_cnt_q[3:0]]; // MSB first
      end else begin
         miso_q <= rx_q[WORD_BITS-2]; // Bit from 16 clocks back
      end
   end

   // Before the first rise the MSB stands; high impedance when deselected
   assign MISO_O = (rise_cnt_q == 5'h0) ? tx_q[WORD_BITS-1] : miso_q;
   assign MISO_OE = ~CS_N;

   // Two-stage synchronisers for select, mode, direction and fault pins
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         meta_q <= 13'h0001;
         sync_q <= 13'h0001;
      end else begin
         meta_q <= {FAULT_IN, DIRECTION_IN_B, DIRECTION_IN_A, OUTPUT_INHIBIT_IN,
                    BRIDGE_WAKE_IN, CS_N};
         sync_q <= meta_q;
      end
   end

   // Select edge detect
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         cs_d1_q <= 1'b1;
      end else begin
         cs_d1_q <= cs_s;
      end
   end

   // Apply received word at select rise
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         mask_q <= MASK_RST;
         slew_q <= SLEW_RST;
         addr_prev_q <= ADDR_FAULT;
      end else if (cs_rise && word_ok_q) begin
         addr_prev_q <= cmd_addr; // Remembered for next load
         if (rx_q[CMD_WR_POS] && cmd_addr == ADDR_MASK) begin
            mask_q <= rx_q[CMD_DATA_HI:0];
         end
         if (rx_q[CMD_WR_POS] && cmd_addr == ADDR_SLEW) begin
            slew_q <= rx_q[2:0];
         end
      end
   end

   // Read view of the addressed register
   always_comb begin
      case (addr_prev_q)
         ADDR_FAULT: reg_rd = fault_s;
         ADDR_MASK: reg_rd = mask_q;
         ADDR_SLEW: reg_rd = {5'h00, slew_q};
         default: reg_rd = 8'h00;
      endcase
   end

   // Transmit word frozen while selected, refreshed while idle
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         tx_q <= '0;
      end else if (cs_s && !cs_rise) begin
         tx_q <= {1'b0, addr_prev_q, 5'h00, reg_rd};
      end
   end

   // Fault flag drive
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= |(fault_s & mask_q);
      end
   end

   assign FAULT_FLAG_N_O = 1'b0;
   assign FAULT_FLAG_N_OE = flag_q;
   assign SLEW_SEL = slew_q;

   // Mode selection, sleep first
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         mode_q <= MODE_SLEEP;
      end else if (!wake_s) begin
         mode_q <= MODE_SLEEP;
      end else if (inh_s) begin
         mode_q <= MODE_STANDBY;
      end else begin
         mode_q <= MODE_ACTIVE;
      end
   end

   assign BRIDGE_MODE = mode_q;

   // One half-bridge per direction input
   for (genvar g = 0; g < 2; g++) begin : g_hb
      always_ff @(posedge CLK_SYS) begin
         if (RESET || mode_q != MODE_ACTIVE) begin
            hs_q[g] <= 1'b0; // Tri-state
            ls_q[g] <= 1'b0;
            drv_q[g] <= 1'b0;
            dead_q[g] <= 6'h00;
         end else begin
            drv_q[g] <= 1'b1;
            if (dead_q[g] != 6'h00) begin
               dead_q[g] <= dead_q[g] - 6'h01; // Both off in gap
            end else if (hs_q[g] != dir_s[g] || ls_q[g] != ~dir_s[g]) begin
               if (hs_q[g] || ls_q[g]) begin
                  hs_q[g] <= 1'b0; // Break before make
                  ls_q[g] <= 1'b0;
                  dead_q[g] <= DEAD_CYC;
               end else begin
                  hs_q[g] <= dir_s[g]; // Own input per output
                  ls_q[g] <= ~dir_s[g];
               end
            end
         end
      end

      // No overlap, dead gap after low side opens, high side only with its input
      no_overlap_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
         !(hs_q[g] && ls_q[g]))
         else $error("both switches of a half-bridge on");
      dead_gap_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
         $fell(ls_q[g]) |-> !hs_q[g] [*8])
         else $error("high side closed inside dead gap");
      route_dir_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
         hs_q[g] |-> $past(dir_s[g]))
         else $error("high side on without its direction input");
   end

   assign BRIDGE_OUT_A = '{drv_en: drv_q[0], hs_on: hs_q[0], ls_on: ls_q[0]};
   assign BRIDGE_OUT_B = '{drv_en: drv_q[1], hs_on: hs_q[1], ls_on: ls_q[1]};

   // Mode, flag, data output and mask write checks
   sleep_mode_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !wake_s |=> mode_q == MODE_SLEEP ##1 drv_q == 2'b00)
      else $error("wake low did not reach sleep with drivers off");
   standby_mode_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      wake_s && inh_s |=> mode_q == MODE_STANDBY)
      else $error("inhibit did not give standby");
   active_mode_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      wake_s && !inh_s |=> mode_q == MODE_ACTIVE)
      else $error("wake with no inhibit did not give active");
   fault_flag_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (|(fault_s & mask_q)) |=> FAULT_FLAG_N_OE && !FAULT_FLAG_N_O)
      else $error("unmasked fault not flagged");
   miso_hiz_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      CS_N |-> !MISO_OE)
      else $error("data output driven while deselected");
   mask_apply_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      cs_rise && word_ok_q && rx_q[CMD_WR_POS] && cmd_addr == ADDR_MASK
      |=> mask_q == $past(rx_q[CMD_DATA_HI:0]))
      else $error("mask write not applied at select rise");
endmodule : mbsc_top

// ---- test_motor_bridge_spi_control.sv ----
/*
 Self-checking bench of the bridge control block: modes, steering, flag and serial.
 Assumes the design files and the serial master model are compiled first.
*/
`timescale 1ns/1ps
module test_motor_bridge_spi_control;
   import mbsc_pkg::*;
   logic clk_sys = 1'b0; // System clock
   logic reset = 1'b1; // Synchronous reset
   logic wake = 1'b0; // Bridge wake pin
   logic inhibit = 1'b0; // Output inhibit pin
   logic dir_a = 1'b0; // Direction inputs
   logic dir_b = 1'b1;
   logic [7:0] fault = 8'h00; // Fault conditions
   wire sclk, cs_n, mosi, miso_o, miso_oe, flag_o, flag_oe;
   wire miso_w = miso_oe ? miso_o : 1'bz; // Released data line floats
   wire flag_w = flag_oe ? flag_o : 1'b1; // Pull-up on the flag
   mbsc_hb_t out_a, out_b;
   logic [2:0] slew;
   mbsc_mode_t mode;
   int failures = 0;
   int n_compared = 0;
   // Clock of 10 ns
   always #5 clk_sys = ~clk_sys;
   mbsc_top u_dut (.CLK_SYS(clk_sys), .RESET(reset), .SCLK(sclk), .CS_N(cs_n),
      .MOSI(mosi), .MISO_O(miso_o), .MISO_OE(miso_oe), .BRIDGE_WAKE_IN(wake),
      .OUTPUT_INHIBIT_IN(inhibit), .DIRECTION_IN_A(dir_a), .DIRECTION_IN_B(dir_b),
      .FAULT_IN(fault), .BRIDGE_OUT_A(out_a), .BRIDGE_OUT_B(out_b),
      .FAULT_FLAG_N_O(flag_o), .FAULT_FLAG_N_OE(flag_oe), .SLEW_SEL(slew),
      .BRIDGE_MODE(mode));
   mbsc_spi_master u_master (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));
   // Compare one value
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   // Report and end the run
   task automatic finish_test;
      $display("Compared %0d values, %0d failures", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   // Set mode pins at a falling edge, then let n cycles pass
   task automatic pins(input logic w, input logic i, input int n);
      @(negedge clk_sys);
      wake = w;
      inhibit = i;
      repeat (n) @(negedge clk_sys);
   endtask : pins
   // Both switches of one half-bridge on is never allowed
   always @(negedge clk_sys) begin
      if (!reset && ((out_a.hs_on && out_a.ls_on) || (out_b.hs_on && out_b.ls_on)))
         check(1'b1, 1'b0);
   end
   // Mode pins, sleep outranking standby
   task automatic test_modes;
      check(mode, MODE_SLEEP);
      check({out_a, out_b}, 6'h00);
      pins(1'b1, 1'b0, 8);
      check(mode, MODE_ACTIVE);
      pins(1'b1, 1'b1, 8);
      check(mode, MODE_STANDBY);
      check({out_a, out_b}, 6'h00);
      pins(1'b0, 1'b1, 8);
      check(mode, MODE_SLEEP);
      check({out_a, out_b}, 6'h00);
      pins(1'b1, 1'b0, 70);
   endtask : test_modes
   // Steering and dead gap on a direction change
   task automatic test_dir;
      int cnt;
      check(out_a, 3'h5);
      check(out_b, 3'h6);
      dir_a = 1'b1;
      repeat (6) @(negedge clk_sys);
      check(out_a, 3'h4);
      for (cnt = 6; cnt < 90 && out_a.hs_on !== 1'b1; cnt++) @(negedge clk_sys);
      if (cnt == 90) begin
         failures++;
         finish_test;
      end
      check(cnt >= 52 && cnt <= 58, 1'b1);
      check(out_a, 3'h6);
      check(out_b, 3'h6);
   endtask : test_dir
   // Serial writes, readback, echo, refused frame and fault flag
   task automatic test_spi;
      logic [31:0] rx;
      check(slew, SLEW_RST);
      u_master.xfer(16, 32'h0000C005, rx);
      check(rx[15:0], 16'h0000);
      check(slew, 3'h5);
      u_master.xfer(32, 32'hA5C34000, rx);
      check(rx[31:16], 16'h4005);
      check(rx[15:0], 16'hA5C3);
      check(miso_oe, 1'b0);
      // Short frame: even if applied it would only read slew, its write bit being 0
      u_master.xfer(15, 32'h00004002, rx);
      check(rx[14:0], 15'h2002);
      check(slew, 3'h5);
      u_master.xfer(16, 32'h0000A001, rx);
      check(rx[15:0], 16'h4005);
      @(negedge clk_sys);
      fault = 8'h02;
      repeat (8) @(negedge clk_sys);
      check(flag_w, 1'b1);
      fault = 8'h01;
      repeat (8) @(negedge clk_sys);
      check(flag_w, 1'b0);
      u_master.xfer(16, 32'h00000000, rx);
      check(rx[15:0], 16'h2001);
      u_master.xfer(16, 32'h00000000, rx);
      check(rx[15:0], 16'h0001);
   endtask : test_spi
   // Main sequence
   initial begin
      repeat (8) @(negedge clk_sys);
      reset = 1'b0;
      repeat (6) @(negedge clk_sys);
      #3;
      test_modes;
      test_dir;
      test_spi;
      finish_test;
   end
   // Cut a hang short
   initial begin
      #500000;
      failures++;
      finish_test;
   end
endmodule : test_motor_bridge_spi_control
